// >>> core/sfr_pkg.sv
package sfr_pkg;

    // Register map
    localparam logic [11:0] ADDR_RELEASE_DELAY = 12'h200;
    localparam logic [11:0] ADDR_REPORT_ZERO = 12'h210;
    localparam logic [11:0] ADDR_REPORT_ONE = 12'h211;
    localparam logic [11:0] ADDR_REPORT_TWO = 12'h212;
    localparam logic [11:0] ADDR_STATUS = 12'h21f;
    localparam logic [11:0] ADDR_LANE_MODE = 12'h21e;

    // Field layout
    localparam int DELAY_LSB = 0;
    localparam int DELAY_W = 5;
    localparam int LANE_MODE_W = 2;

    // Reset values
    localparam logic [4:0] RELEASE_DELAY_RESET = 5'h08;
    localparam logic [4:0] REPORT_RESET = 5'h00;
    localparam logic [1:0] LANE_MODE_RESET = 2'h0;

    // Report offsets
    localparam logic [5:0] OFFSET_ONE = 6'h01;
    localparam logic [5:0] OFFSET_TWO_MODE0 = 6'h02;
    localparam logic [5:0] OFFSET_TWO_OTHER = 6'h00;

    // Arrival counter saturates above the report range
    localparam logic [5:0] COUNT_MAX = 6'h3f;

    // Number of measured FIFOs
    localparam int NUM_FIFO = 3;

    typedef enum logic [1:0] {
        SFR_IDLE,
        SFR_COUNT,
        SFR_DONE
    } sfr_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sfr_bus_req_t;

endpackage

// >>> core/sfr_sync.sv
`timescale 1ns/1ps
module sfr_sync
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);

    logic stage1_reg;
    logic stage2_reg;

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule

// >>> core/sfr_arrival_meter.sv
`timescale 1ns/1ps
module sfr_arrival_meter
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Measurement events, synchronous
    input wire logic sysref_rise_in,
    input wire logic sample_seen_in,
    // Latest arrival count
    output logic [5:0] count_out,
    output logic valid_out
);

    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [5:0] res_reg;
    logic [5:0] res_next;
    logic val_reg;
    logic val_next;
    sfr_pkg::sfr_state_t st_reg;
    sfr_pkg::sfr_state_t st_next;

    always_comb
    begin
        cnt_next = cnt_reg;
        res_next = res_reg;
        val_next = val_reg;
        st_next = st_reg;
        case (st_reg)
            sfr_pkg::SFR_IDLE:
            begin
                if (sysref_rise_in)
                begin
                    cnt_next = 6'h00;
                    st_next = sfr_pkg::SFR_COUNT;
                end
            end
            sfr_pkg::SFR_COUNT:
            begin
                if (sample_seen_in)
                begin
                    // Most recent measurement replaces the old one
                    res_next = cnt_reg;
                    val_next = 1'b1;
                    st_next = sfr_pkg::SFR_DONE;
                end
                else if (cnt_reg != sfr_pkg::COUNT_MAX)
                begin
                    cnt_next = cnt_reg + 6'h01;
                end
            end
            sfr_pkg::SFR_DONE:
            begin
                if (sysref_rise_in)
                begin
                    cnt_next = 6'h00;
                    st_next = sfr_pkg::SFR_COUNT;
                end
            end
            default:
            begin
                st_next = sfr_pkg::SFR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cnt_reg <= 6'h00;
            res_reg <= 6'h00;
            val_reg <= 1'b0;
            st_reg <= sfr_pkg::SFR_IDLE;
        end
        else
        begin
            cnt_reg <= cnt_next;
            res_reg <= res_next;
            val_reg <= val_next;
            st_reg <= st_next;
        end
    end

    assign count_out = res_reg;
    assign valid_out = val_reg;

endmodule

// >>> core/sfr_release_delay.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module sfr_release_delay
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Register port
    input wire logic [11:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Converter side, asynchronous levels
    input wire logic sysref_in,
    input wire logic [2:0] sample_avail_in,
    input wire logic [1:0] transmit_gate_in,
    input wire logic oscillator_enable_in,
    // Release, oscillator alignment and write violation flag
    output logic release_out,
    output logic osc_align_out,
    output logic write_violation_out
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic sysref_s;
    logic [2:0] avail_s;
    logic [1:0] gate_s;
    logic osc_en_s;
    logic sysref_d_reg;
    logic sysref_rise;
    logic [2:0] avail_d_reg;
    logic [2:0] avail_rise;

    sfr_sync u_sync_sysref
    (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .async_in(sysref_in),
        .sync_out(sysref_s)
    );

    sfr_sync u_sync_osc
    (
        .core_clk_in(core_clk_in),
        .resetn_in(resetn_in),
        .async_in(oscillator_enable_in),
        .sync_out(osc_en_s)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_gate
            sfr_sync u_sync_gate
            (
                .core_clk_in(core_clk_in),
                .resetn_in(resetn_in),
                .async_in(transmit_gate_in[g]),
                .sync_out(gate_s[g])
            );
        end
        for (g = 0; g < sfr_pkg::NUM_FIFO; g++)
        begin : g_fifo
            sfr_sync u_sync_avail
            (
                .core_clk_in(core_clk_in),
                .resetn_in(resetn_in),
                .async_in(sample_avail_in[g]),
                .sync_out(avail_s[g])
            );
        end
    endgenerate

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sysref_d_reg <= 1'b0;
            avail_d_reg <= 3'h0;
        end
        else
        begin
            sysref_d_reg <= sysref_s;
            avail_d_reg <= avail_s;
        end
    end

    assign sysref_rise = sysref_s & ~sysref_d_reg;
    assign avail_rise = avail_s & ~avail_d_reg;

    ////////////////////////////////////////////////////////////////////////
    // Arrival measurement

    logic [5:0] raw_cnt [sfr_pkg::NUM_FIFO];
    logic [2:0] raw_val;

    generate
        for (g = 0; g < sfr_pkg::NUM_FIFO; g++)
        begin : g_meter
            sfr_arrival_meter u_meter
            (
                .core_clk_in(core_clk_in),
                .resetn_in(resetn_in),
                .sysref_rise_in(sysref_rise),
                .sample_seen_in(avail_rise[g]),
                .count_out(raw_cnt[g]),
                .valid_out(raw_val[g])
            );
        end
    endgenerate

    // Subtract and clamp into the five-bit report range
    function automatic logic [4:0] clamp_sub(input logic [5:0] v,
                                             input logic [5:0] off);
        logic [6:0] diff;
        diff = {1'b0, v} - {1'b0, off};
        if (diff[6])
            clamp_sub = 5'h00;
        else if (diff[5])
            clamp_sub = 5'h1f;
        else
            clamp_sub = diff[4:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [4:0] delay_reg;
    logic [4:0] delay_next;
    logic [1:0] lane_mode_reg;
    logic [1:0] lane_mode_next;
    logic [4:0] rep_reg [sfr_pkg::NUM_FIFO];
    logic [4:0] rep_next [sfr_pkg::NUM_FIFO];
    logic viol_reg;
    logic viol_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [5:0] off_two;
    logic safe_change;

    // Data path must be quiet for a delay change to be glitch free
    assign safe_change = (gate_s == 2'b00) && !osc_en_s;
    assign off_two = (lane_mode_reg == 2'h0) ? sfr_pkg::OFFSET_TWO_MODE0
                                             : sfr_pkg::OFFSET_TWO_OTHER;

    always_comb
    begin
        delay_next = delay_reg;
        lane_mode_next = lane_mode_reg;
        viol_next = viol_reg;
        rdata_next = 8'h00;
        rep_next[0] = raw_val[0] ? clamp_sub(raw_cnt[0], 6'h00)
                                 : rep_reg[0];
        rep_next[1] = raw_val[1] ? clamp_sub(raw_cnt[1], sfr_pkg::OFFSET_ONE)
                                 : rep_reg[1];
        rep_next[2] = raw_val[2] ? clamp_sub(raw_cnt[2], off_two)
                                 : rep_reg[2];
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                sfr_pkg::ADDR_RELEASE_DELAY:
                begin
                    delay_next = reg_wdata_in[4:0];
                    // Write still lands; the flag records the misuse
                    if (!safe_change)
                        viol_next = 1'b1;
                end
                sfr_pkg::ADDR_LANE_MODE:
                    lane_mode_next = reg_wdata_in[1:0];
                sfr_pkg::ADDR_STATUS:
                    if (reg_wdata_in[0])
                        viol_next = 1'b0;
                default: viol_next = viol_reg;
            endcase
        end
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                sfr_pkg::ADDR_RELEASE_DELAY: rdata_next = {3'h0, delay_reg};
                sfr_pkg::ADDR_REPORT_ZERO: rdata_next = {3'h0, rep_reg[0]};
                sfr_pkg::ADDR_REPORT_ONE: rdata_next = {3'h0, rep_reg[1]};
                sfr_pkg::ADDR_REPORT_TWO: rdata_next = {3'h0, rep_reg[2]};
                sfr_pkg::ADDR_LANE_MODE: rdata_next = {6'h00, lane_mode_reg};
                sfr_pkg::ADDR_STATUS:
                    rdata_next = {5'h00, osc_en_s, safe_change, viol_reg};
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            delay_reg <= sfr_pkg::RELEASE_DELAY_RESET;
            lane_mode_reg <= sfr_pkg::LANE_MODE_RESET;
            viol_reg <= 1'b0;
            rdata_reg <= 8'h00;
            for (int i = 0; i < sfr_pkg::NUM_FIFO; i++)
                rep_reg[i] <= sfr_pkg::REPORT_RESET;
        end
        else
        begin
            delay_reg <= delay_next;
            lane_mode_reg <= lane_mode_next;
            viol_reg <= viol_next;
            rdata_reg <= rdata_next;
            for (int i = 0; i < sfr_pkg::NUM_FIFO; i++)
                rep_reg[i] <= rep_next[i];
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign write_violation_out = viol_reg;

    ////////////////////////////////////////////////////////////////////////
    // Release timer; also times the oscillator alignment point

    logic [4:0] rel_cnt_reg;
    logic [4:0] rel_cnt_next;
    logic rel_run_reg;
    logic rel_run_next;
    logic release_reg;
    logic release_next;

    always_comb
    begin
        rel_cnt_next = rel_cnt_reg;
        rel_run_next = rel_run_reg;
        release_next = 1'b0;
        if (sysref_rise)
        begin
            rel_cnt_next = delay_reg;
            rel_run_next = 1'b1;
        end
        else if (rel_run_reg)
        begin
            if (rel_cnt_reg == 5'h00)
            begin
                release_next = 1'b1;
                rel_run_next = 1'b0;
            end
            else
                rel_cnt_next = rel_cnt_reg - 5'h01;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rel_cnt_reg <= 5'h00;
            rel_run_reg <= 1'b0;
            release_reg <= 1'b0;
        end
        else
        begin
            rel_cnt_reg <= rel_cnt_next;
            rel_run_reg <= rel_run_next;
            release_reg <= release_next;
        end
    end

    assign release_out = release_reg;
    assign osc_align_out = release_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_reset_delay;
        @(posedge core_clk_in)
        $rose(resetn_in) |-> delay_reg == sfr_pkg::RELEASE_DELAY_RESET;
    endproperty
    a_reset_delay: assert property (p_reset_delay)
        else $error("Release delay not eight after reset");
    property p_release_time;
        @(posedge core_clk_in) disable iff (!resetn_in)
        (sysref_rise && delay_reg == 5'h03) ##1 !sysref_rise [*4]
            |=> release_reg;
    endproperty
    a_release_time: assert property (p_release_time)
        else $error("Release not at programmed delay");
    property p_align_follows;
        @(posedge core_clk_in) osc_align_out == release_out;
    endproperty
    a_align_follows: assert property (p_align_follows)
        else $error("Oscillator alignment not tied to release");
    property p_rep0;
        @(posedge core_clk_in) disable iff (!resetn_in)
        raw_val[0] && !raw_cnt[0][5] |=> rep_reg[0] == $past(raw_cnt[0][4:0]);
    endproperty
    a_rep0: assert property (p_rep0)
        else $error("Report zero wrong");
    // Whole in-range span, counts 1 to 32; counts that clamp are not checked
    property p_rep1;
        @(posedge core_clk_in) disable iff (!resetn_in)
        raw_val[1] && raw_cnt[1] inside {[6'h01:6'h20]}
            |=> rep_reg[1] == 5'($past(raw_cnt[1]) - 6'h01);
    endproperty
    a_rep1: assert property (p_rep1)
        else $error("Report one offset wrong");
    property p_rep2;
        @(posedge core_clk_in) disable iff (!resetn_in)
        raw_val[2] && lane_mode_reg == 2'h0 &&
            raw_cnt[2] inside {[6'h02:6'h21]}
            |=> rep_reg[2] == 5'($past(raw_cnt[2]) - 6'h02);
    endproperty
    a_rep2: assert property (p_rep2)
        else $error("Report two offset wrong");
    property p_rd_upper;
        @(posedge core_clk_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in[11:4] == 8'h21
            |=> reg_rdata_out[7:5] == 3'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("Report upper bits not zero");
    property p_clamp;
        @(posedge core_clk_in) disable iff (!resetn_in)
        raw_val[0] && raw_cnt[0] > 6'h1f |=> rep_reg[0] == 5'h1f;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("Report not clamped high");
    c_release: cover property (@(posedge core_clk_in) release_reg);
    c_rep2_other: cover property (@(posedge core_clk_in)
        raw_val[2] && lane_mode_reg != 2'h0);
    c_violation: cover property (@(posedge core_clk_in) $rose(viol_reg));

endmodule

// >>> test/sfr_lane_model.sv
`timescale 1ns/1ps
module sfr_lane_model
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic resetn_in,
    // Frame control from the bench
    input wire logic start_in,
    input wire logic [17:0] gaps_in,
    // Lines into the device
    output logic sysref_out,
    output logic [2:0] sample_avail_out
);
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;

    ////////////////////////////////////////////////////////////////////////
    // Cycles since the reference rose, saturating so late lanes still rise
    always_comb
    begin
        cnt_next = cnt_reg;
        if (!start_in)
            cnt_next = 6'h00;
        else if (cnt_reg != 6'h3f)
            cnt_next = cnt_reg + 6'h01;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            cnt_reg <= 6'h00;
        else
            cnt_reg <= cnt_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Everything drops between frames, so no stale edge is left pending
    assign sysref_out = start_in;

    always_comb
    begin
        for (int i = 0; i < 3; i++)
            sample_avail_out[i] = start_in && (cnt_reg >= gaps_in[i*6 +: 6]);
    end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            $display("[ERR] %s expected %h seen %h", nm, exp, got); \
            num_errors++; \
        end \
    end

module tb;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sysref;
    logic [2:0] avail;
    logic [1:0] gate = 2'h0;
    logic osc_en = 1'b0;
    logic release_p;
    logic osc_align;
    logic viol;
    logic start = 1'b0;
    logic [17:0] gaps = 18'h00000;
    int num_errors = 0;
    int n_tests = 0;
    int t0;
    int t;
    int w;
    logic [7:0] dly[4] = '{8'h00, 8'h03, 8'h08, 8'h1f};
    logic [17:0] mg[5] = '{{6'h0c, 6'h0c, 6'h0c}, {6'h0c, 6'h0c, 6'h0c},
        {6'h14, 6'h09, 6'h05}, {6'h28, 6'h28, 6'h28},
        {6'h01, 6'h21, 6'h28}};
    logic [1:0] mm[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
    // Count is the lane gap less one; a one-cycle gap reads zero
    logic [23:0] me[5] = '{24'h090a0b, 24'h0b0a0b, 24'h130704,
        24'h1f1f1f, 24'h001f1f};

    always #4 core_clk = ~core_clk;

    sfr_release_delay dut
    (
        .core_clk_in(core_clk),
        .resetn_in(resetn),
        .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata),
        .sysref_in(sysref),
        .sample_avail_in(avail),
        .transmit_gate_in(gate),
        .oscillator_enable_in(osc_en),
        .release_out(release_p),
        .osc_align_out(osc_align),
        .write_violation_out(viol)
    );

    sfr_lane_model lanes
    (
        .core_clk_in(core_clk),
        .resetn_in(resetn),
        .start_in(start),
        .gaps_in(gaps),
        .sysref_out(sysref),
        .sample_avail_out(avail)
    );

    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task chk_rd(input string nm, input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        `CHK(nm, e, reg_rdata)
    endtask

    // Frame long enough for the largest delay and the latest lane
    task frame(input logic [17:0] g, output int first, output int width);
        first = -1;
        width = 0;
        @(posedge core_clk);
        start <= 1'b1;
        gaps <= g;
        for (int i = 0; i < 64; i++)
        begin
            @(posedge core_clk);
            #1;
            if (release_p === 1'b1)
            begin
                if (first < 0)
                    first = i;
                width++;
            end
        end
        @(posedge core_clk);
        start <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask

    // Mid-cycle, away from the edge that updates both outputs
    always @(negedge core_clk)
    begin
        if (resetn)
            `CHK("osc_align", release_p, osc_align)
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        chk_rd("delay_rst", sfr_pkg::ADDR_RELEASE_DELAY, 8'h08);
        chk_rd("rep0_rst", sfr_pkg::ADDR_REPORT_ZERO, 8'h00);
        chk_rd("rep1_rst", sfr_pkg::ADDR_REPORT_ONE, 8'h00);
        chk_rd("rep2_rst", sfr_pkg::ADDR_REPORT_TWO, 8'h00);
        chk_rd("lane_rst", sfr_pkg::ADDR_LANE_MODE, 8'h00);
        chk_rd("unmapped", 12'h3ff, 8'h00);
        @(posedge core_clk);
        #1;
        `CHK("rdata_idle", 8'h00, reg_rdata)
        $display("test reset done");

        wr(sfr_pkg::ADDR_RELEASE_DELAY, 8'hff);
        chk_rd("delay_rw", sfr_pkg::ADDR_RELEASE_DELAY, 8'h1f);
        wr(sfr_pkg::ADDR_REPORT_ONE, 8'hff);
        chk_rd("rep_ro", sfr_pkg::ADDR_REPORT_ONE, 8'h00);
        wr(12'h3ff, 8'h55);
        chk_rd("unmapped_wr", 12'h3ff, 8'h00);
        $display("test access done");

        // Absolute latency is pipeline detail; the shift must equal delay
        for (int j = 0; j < 4; j++)
        begin
            wr(sfr_pkg::ADDR_RELEASE_DELAY, dly[j]);
            frame(18'h00000, t, w);
            if (j == 0)
                t0 = t;
            `CHK("release_at", t0 + int'(dly[j]), t)
            `CHK("release_len", 1, w)
        end
        chk_rd("status_safe", sfr_pkg::ADDR_STATUS, 8'h02);
        $display("test release done");

        for (int r = 0; r < 5; r++)
        begin
            wr(sfr_pkg::ADDR_LANE_MODE, {6'h00, mm[r]});
            frame(mg[r], t, w);
            chk_rd("rep0", sfr_pkg::ADDR_REPORT_ZERO, me[r][7:0]);
            chk_rd("rep1", sfr_pkg::ADDR_REPORT_ONE, me[r][15:8]);
            chk_rd("rep2", sfr_pkg::ADDR_REPORT_TWO, me[r][23:16]);
        end
        $display("test measure done");

        for (int g = 1; g < 4; g++)
        begin
            gate <= 2'(g);
            repeat (4) @(posedge core_clk);
            wr(sfr_pkg::ADDR_RELEASE_DELAY, 8'h05);
            repeat (3) @(posedge core_clk);
            #1;
            `CHK("violation", 1'b1, viol)
            chk_rd("status_gate", sfr_pkg::ADDR_STATUS, 8'h01);
            gate <= 2'h0;
            repeat (4) @(posedge core_clk);
            wr(sfr_pkg::ADDR_STATUS, 8'h01);
            chk_rd("status_clr", sfr_pkg::ADDR_STATUS, 8'h02);
        end
        osc_en <= 1'b1;
        repeat (4) @(posedge core_clk);
        wr(sfr_pkg::ADDR_RELEASE_DELAY, 8'h08);
        chk_rd("status_osc", sfr_pkg::ADDR_STATUS, 8'h05);
        chk_rd("delay_kept", sfr_pkg::ADDR_RELEASE_DELAY, 8'h08);
        osc_en <= 1'b0;
        repeat (4) @(posedge core_clk);
        wr(sfr_pkg::ADDR_STATUS, 8'h01);
        chk_rd("status_end", sfr_pkg::ADDR_STATUS, 8'h02);
        $display("test violation done");
        stop_test();
    end

    // Whole run is under a thousand cycles; this leaves a wide margin
    initial
    begin
        #200000;
        num_errors++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
